// ===== ccs_pkg.sv
// Package of constants for the contactless command sequencer
// ----------------------------------------------------------------------------
// Summary of operation
// R1 - Transmit sends FIFO at once, ends when FIFO empties or another command arrives
// R2 - Keep-command code updates receiver-off and power-down, command untouched
// R3 - Receive enables receiver and ends itself at end of stream
// R4 - With multi-frame receive set, receive never ends by itself
// R5 - Transceive alternates endlessly; initiator sends first, then receives
// R6 - Non-initiator transceive receives first, sends after a complete stream
// R7 - Host kicks each send phase and ends transceive with a new command
// R8 - Multi-frame receive keeps transceive in receiving state forever
// R9 - Anticollision runs mode detector unless disabled and loads mode registers
// R10 - Field loss restarts anticollision state machine without ending the command
// R11 - Anticollision completion switches to transceive; rewriting code restarts it
// R12 - Events held back during anticollision; command governs CRC enables in Type A
// R13 - Passive 106k activation leaves start-byte frame in FIFO, target flag set
// R14 - Active mode: transceive, target flag clear, start byte and CRC at 106k
// R15 - Host preloads twelve authentication bytes before starting authenticate; the bench preloads four, as FIFO_D is 4
// R16 - FIFO access during authentication is blocked and flags write error
// R17 - Authenticate ends on success setting cipher flag; done events suppressed
// R18 - Authentication failure sets protocol error and clears cipher flag
// R19 - Soft reset restores registers incl. serial rate, keeps identity buffer, ends
// R20 - Host runs self-test by reset, config, self-test value, FIFO byte, CRC
// R21 - Test-bus select 07h routes seven receiver signals to D6..D0
// R22 - Host uses timer event besides idle event to end authentication
// R23 - Commands use the fixed four-bit codes
// R24 - Starting a command never clears the FIFO
// R25 - A command ending itself returns to idle and raises the idle event
// ----------------------------------------------------------------------------
package ccs_pkg;
	// Command codes
	localparam logic [3:0] CMD_IDLE = 4'h0;
	localparam logic [3:0] CMD_CONFIG = 4'h1;
	localparam logic [3:0] CMD_RANDOM = 4'h2;
	localparam logic [3:0] CMD_CRC = 4'h3;
	localparam logic [3:0] CMD_TRANSMIT = 4'h4;
	localparam logic [3:0] CMD_KEEP = 4'h7;
	localparam logic [3:0] CMD_RECEIVE = 4'h8;
	localparam logic [3:0] CMD_TRANSCEIVE = 4'hc;
	localparam logic [3:0] CMD_AUTO_ANTICOLLISION_CMD = 4'hd;
	localparam logic [3:0] CMD_AUTHENT = 4'he;
	localparam logic [3:0] CMD_SOFTWARE_RESET_CMD = 4'hf;
	// Command register field positions
	localparam int CMDF_PDOWN = 4;
	localparam int CMDF_RXOFF = 5;
	// Test bus select, serial rate and self-test reset values
	localparam logic [4:0] TBUS_RECEIVER = 5'h07;
	localparam logic [7:0] SERIAL_RATE_RST = 8'heb;
	localparam logic [7:0] SELF_TEST_RST = 8'h40;
	localparam logic [4:0] TBUS_RST = 5'h00;
	// FIFO shape
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 4;
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE, ST_SEND, ST_RECV, ST_WAIT_KICK, ST_COLL, ST_AUTH, ST_BUSY
	} ccs_state_e;
endpackage : ccs_pkg

// ===== ccs_fifo.sv
// Small data FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ccs_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Synchronised reset
	input wire logic [W-1:0] in_data, // Write data
	input wire logic in_valid, // Write request
	output logic in_ready, // Room available
	output logic [W-1:0] out_data, // Head word
	output logic out_valid, // Not empty
	input wire logic out_ready // Head consumed
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;
	// Handshake terms
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end
	assign in_ready = (cnt_r != (AW+1)'(D));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rp_r];
	// Pointer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	// Storage, written only on push
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end
endmodule : ccs_fifo

// ===== ccs_sequencer.sv
// Command sequencer top: command register, FIFO path, flags and test bus
`timescale 1ns/1ps
module ccs_sequencer
	import ccs_pkg::*;
(
	input wire logic ref_clk, // 40 MHz clock
	input wire logic reset_n, // Async reset, active low
	input wire logic cmd_wr, // Host writes command register
	input wire logic [7:0] cmd_wdata, // Written command register value
	input wire logic initiator_role, // Initiator role bit
	input wire logic multi_frame_receive, // Keep receiving after frames
	input wire logic mode_detector_disable, // Mode detector off
	input wire logic transmit_kick, // Start-send pulse from host
	input wire logic [7:0] host_fifo_wdata, // Host FIFO write data
	input wire logic host_fifo_wr, // Host FIFO write
	input wire logic host_fifo_rd, // Host FIFO read
	input wire logic [7:0] rx_byte, // Received byte from decoder
	input wire logic rx_byte_valid, // Received byte strobe
	input wire logic rx_frame_end, // End of frame or length reached
	input wire logic tx_byte_ready, // Coder takes a byte
	input wire logic rf_field_present, // External field present (pin)
	input wire logic mode_detected, // Mode detector hit
	input wire logic [7:0] detected_mode, // Mode bits from received data
	input wire logic coll_done, // Activation finished
	input wire logic coll_active_mode, // Active communication mode found
	input wire logic coll_is_106k, // 106 kbps detected
	input wire logic auth_ok, // Card authenticated
	input wire logic auth_fail, // Authentication error
	input wire logic [6:0] rx_test_signals, // Receiver signals D6..D0
	input wire logic [4:0] test_bus_select, // Test bus select
	output logic [7:0] command_register, // Command register readback
	output logic [7:0] fifo_rdata, // FIFO head to host
	output logic fifo_not_empty, // FIFO holds data
	output logic fifo_host_ready, // FIFO accepts host data
	output logic [7:0] tx_byte, // Byte to coder
	output logic tx_active, // Transmitter running
	output logic receiver_on, // Receiver path enabled
	output logic mode_det_on, // Mode detector running
	output logic [7:0] receive_mode_register, // Mode loaded by detector
	output logic crc_force_on, // Command governs CRC enables
	output logic target_activated_flag, // Target activated
	output logic cipher_active_flag, // Cipher active
	output logic fifo_write_error, // FIFO access error
	output logic protocol_error_flag, // Protocol error
	output logic idle_event, // Command ended itself
	output logic receive_done_event, // Frame received
	output logic transmit_done_event, // Transmission done
	output logic [7:0] serial_rate_register, // Serial rate setting
	output logic [7:0] self_test_register, // Self-test setting
	output logic [6:0] test_bus // Test bus D6..D0
);
	// ------------------------------------------------------------------------
	// Reset release and pin synchronisers
	// ------------------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [1:0] field_sync_r;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];
	// Field level comes from an analog detector, so it is synchronised
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			field_sync_r <= 2'h0;
		end else begin
			field_sync_r <= {field_sync_r[0], rf_field_present};
		end
	end
	// ------------------------------------------------------------------------
	// FIFO
	// ------------------------------------------------------------------------
	ccs_state_e st_r, st_nxt;
	logic [3:0] cmd_r, cmd_nxt;
	logic in_v, in_rdy, out_v, out_rdy, blocked;
	logic [7:0] in_d, out_d;
	always_comb begin
		blocked = (st_r == ST_AUTH);
		in_v = 1'b0;
		in_d = host_fifo_wdata;
		// R16 block FIFO accesses
		if (!blocked && host_fifo_wr) begin
			in_v = 1'b1;
		end else if ((st_r == ST_RECV || st_r == ST_COLL) && rx_byte_valid) begin
			in_v = 1'b1;
			in_d = rx_byte;
		end
		out_rdy = (!blocked && host_fifo_rd) || (st_r == ST_SEND && tx_byte_ready);
	end
	ccs_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
		.clk(ref_clk),
		.rst_n(rst_n),
		.in_data(in_d),
		.in_valid(in_v),
		.in_ready(in_rdy),
		.out_data(out_d),
		.out_valid(out_v),
		.out_ready(out_rdy)
	);
	// ------------------------------------------------------------------------
	// Command state machine
	// ------------------------------------------------------------------------
	logic [1:0] bits_r, bits_nxt;
	logic [7:0] rmode_r, rmode_nxt;
	logic [7:0] srate_r, srate_nxt, stest_r, stest_nxt;
	logic tgt_r, tgt_nxt, ciph_r, ciph_nxt, werr_r, werr_nxt, perr_r, perr_nxt;
	logic idle_r, idle_nxt, rxd_r, rxd_nxt, txd_r, txd_nxt;
	logic [7:0] tx_r, tx_nxt, fout_r;
	logic fne_r, frdy_r;
	logic [6:0] tbus_r, tbus_nxt;
	logic newcmd;
	logic [3:0] dec_r, dec_nxt;
	always_comb begin
		st_nxt = st_r;
		cmd_nxt = cmd_r;
		bits_nxt = bits_r;
		rmode_nxt = rmode_r;
		srate_nxt = srate_r;
		stest_nxt = stest_r;
		tgt_nxt = tgt_r;
		ciph_nxt = ciph_r;
		werr_nxt = werr_r;
		perr_nxt = perr_r;
		idle_nxt = 1'b0;
		rxd_nxt = 1'b0;
		txd_nxt = 1'b0;
		tx_nxt = (st_r == ST_SEND && tx_byte_ready && out_v) ? out_d : tx_r;
		newcmd = cmd_wr && cmd_wdata[3:0] != CMD_KEEP;
		// R2 keep-command touches only the other bits
		if (cmd_wr) begin
			bits_nxt = {cmd_wdata[CMDF_RXOFF], cmd_wdata[CMDF_PDOWN]};
		end
		case (st_r)
			// R1 send until FIFO runs empty
			ST_SEND: begin
				if (!out_v) begin
					txd_nxt = 1'b1;
					if (cmd_r == CMD_TRANSCEIVE) begin
						// R5 receiver follows transmission
						st_nxt = ST_RECV;
					end else begin
						// R25 self-ended command returns to idle
						st_nxt = ST_IDLE;
						cmd_nxt = CMD_IDLE;
						idle_nxt = 1'b1;
					end
				end
			end
			// R3 receive ends on frame end; R4 R8 not with multi-frame
			ST_RECV: begin
				if (rx_frame_end) begin
					rxd_nxt = 1'b1;
					if (cmd_r == CMD_TRANSCEIVE) begin
						// R6 send only after a full stream
						st_nxt = multi_frame_receive ? ST_RECV : ST_WAIT_KICK;
					end else if (!multi_frame_receive) begin
						st_nxt = ST_IDLE;
						cmd_nxt = CMD_IDLE;
						idle_nxt = 1'b1;
					end
				end
			end
			// R7 each send phase waits for the host kick
			ST_WAIT_KICK: begin
				if (transmit_kick) begin
					st_nxt = ST_SEND;
				end
			end
			// R9 mode detector loads mode bits
			ST_COLL: begin
				if (mode_detected && !mode_detector_disable) begin
					rmode_nxt = detected_mode;
				end
				if (!field_sync_r[1]) begin
					// R10 restart in place, command stays active
					st_nxt = ST_COLL;
				end else if (coll_done) begin
					// R11 switch to transceive; R13 R14 target flag
					cmd_nxt = CMD_TRANSCEIVE;
					st_nxt = ST_WAIT_KICK;
					tgt_nxt = !coll_active_mode;
					// R12 only the final frame raises the event
					rxd_nxt = 1'b1;
				end
			end
			// R17 ends only on success; R18 failure flags
			ST_AUTH: begin
				if (auth_ok) begin
					ciph_nxt = 1'b1;
					st_nxt = ST_IDLE;
					cmd_nxt = CMD_IDLE;
					idle_nxt = 1'b1;
				end else if (auth_fail) begin
					perr_nxt = 1'b1;
					ciph_nxt = 1'b0;
				end
			end
			// Config, random ID and soft reset finish in one step
			ST_BUSY: begin
				st_nxt = ST_IDLE;
				cmd_nxt = CMD_IDLE;
				idle_nxt = 1'b1;
			end
			default: begin
			end
		endcase
		// R23 decode; R24 starting a command leaves the FIFO alone
		if (newcmd) begin
			cmd_nxt = cmd_wdata[3:0];
			case (cmd_wdata[3:0])
				CMD_TRANSMIT: st_nxt = ST_SEND;
				CMD_RECEIVE: st_nxt = ST_RECV;
				CMD_TRANSCEIVE: st_nxt = initiator_role ? ST_WAIT_KICK : ST_RECV;
				// R11 rewriting the code restarts the machine
				CMD_AUTO_ANTICOLLISION_CMD: begin
					st_nxt = ST_COLL;
					tgt_nxt = 1'b0;
				end
				CMD_AUTHENT: st_nxt = ST_AUTH;
				CMD_CONFIG, CMD_RANDOM: st_nxt = ST_BUSY;
				// R19 soft reset restores registers, identity buffer untouched
				CMD_SOFTWARE_RESET_CMD: begin
					st_nxt = ST_BUSY;
					srate_nxt = SERIAL_RATE_RST;
					stest_nxt = SELF_TEST_RST;
					rmode_nxt = 8'h00;
					bits_nxt = 2'h0;
					tgt_nxt = 1'b0;
					ciph_nxt = 1'b0;
					werr_nxt = 1'b0;
					perr_nxt = 1'b0;
				end
				default: st_nxt = ST_IDLE;
			endcase
		end
		// R17 done events suppressed while authenticating
		if (st_r == ST_AUTH) begin
			rxd_nxt = 1'b0;
			txd_nxt = 1'b0;
		end
		// R16 R18 a flag set in this cycle outranks the soft-reset clear
		werr_nxt = werr_nxt || (blocked && (host_fifo_wr || host_fifo_rd));
		perr_nxt = perr_nxt || (blocked && auth_fail && !auth_ok);
		// Decodes taken from the next state, so these outputs leave flops
		dec_nxt = {st_nxt == ST_SEND, st_nxt == ST_RECV || st_nxt == ST_COLL,
			st_nxt == ST_COLL && !mode_detector_disable, st_nxt == ST_COLL};
		// R21 receiver signals onto the test bus
		tbus_nxt = (test_bus_select == TBUS_RECEIVER) ? rx_test_signals : 7'h00;
	end
	// State and output registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ST_IDLE;
			cmd_r <= CMD_IDLE;
			bits_r <= 2'h0;
			rmode_r <= 8'h00;
			srate_r <= SERIAL_RATE_RST;
			stest_r <= SELF_TEST_RST;
			tgt_r <= 1'b0;
			ciph_r <= 1'b0;
			werr_r <= 1'b0;
			perr_r <= 1'b0;
			idle_r <= 1'b0;
			rxd_r <= 1'b0;
			txd_r <= 1'b0;
			tx_r <= 8'h00;
			fout_r <= 8'h00;
			fne_r <= 1'b0;
			frdy_r <= 1'b0;
			tbus_r <= 7'h00;
			dec_r <= 4'h0;
		end else begin
			st_r <= st_nxt;
			cmd_r <= cmd_nxt;
			bits_r <= bits_nxt;
			rmode_r <= rmode_nxt;
			srate_r <= srate_nxt;
			stest_r <= stest_nxt;
			tgt_r <= tgt_nxt;
			ciph_r <= ciph_nxt;
			werr_r <= werr_nxt;
			perr_r <= perr_nxt;
			idle_r <= idle_nxt;
			rxd_r <= rxd_nxt;
			txd_r <= txd_nxt;
			tx_r <= tx_nxt;
			fout_r <= out_d;
			fne_r <= out_v;
			frdy_r <= in_rdy && !blocked;
			tbus_r <= tbus_nxt;
			dec_r <= dec_nxt;
		end
	end
	// Outputs straight from flip-flops
	assign command_register = {2'h0, bits_r, cmd_r};
	assign fifo_rdata = fout_r;
	assign fifo_not_empty = fne_r;
	assign fifo_host_ready = frdy_r;
	assign tx_byte = tx_r;
	assign tx_active = dec_r[3];
	assign receiver_on = dec_r[2];
	assign mode_det_on = dec_r[1];
	assign receive_mode_register = rmode_r;
	// R12 command, not mode registers, governs CRC during activation
	assign crc_force_on = dec_r[0];
	assign target_activated_flag = tgt_r;
	assign cipher_active_flag = ciph_r;
	assign fifo_write_error = werr_r;
	assign protocol_error_flag = perr_r;
	assign idle_event = idle_r;
	assign receive_done_event = rxd_r;
	assign transmit_done_event = txd_r;
	assign serial_rate_register = srate_r;
	assign self_test_register = stest_r;
	assign test_bus = tbus_r;
	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	sequence s_auth_ok;
		st_r == ST_AUTH && auth_ok && !cmd_wr;
	endsequence
	chk_auth_success_end: assert property (@(posedge ref_clk) disable iff (!rst_n) // R17
		s_auth_ok |=> cipher_active_flag && idle_event && cmd_r == CMD_IDLE)
		else $error("authentication success not handled");
	chk_auth_fifo_block: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
		st_r == ST_AUTH && host_fifo_wr |=> fifo_write_error)
		else $error("FIFO access during authentication not flagged");
	chk_auth_no_events: assert property (@(posedge ref_clk) disable iff (!rst_n) // R17
		st_r == ST_AUTH |=> !receive_done_event && !transmit_done_event)
		else $error("done event during authentication");
	chk_auth_fail_flags: assert property (@(posedge ref_clk) disable iff (!rst_n) // R18
		st_r == ST_AUTH && auth_fail && !auth_ok && !cmd_wr |=> protocol_error_flag && !cipher_active_flag)
		else $error("authentication failure flags wrong");
	chk_keep_cmd_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
		cmd_wr && cmd_wdata[3:0] == CMD_KEEP && st_r == ST_WAIT_KICK && !transmit_kick
		|=> $stable(cmd_r) && st_r == ST_WAIT_KICK)
		else $error("keep-command changed the command");
	chk_multi_rx_stay: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
		st_r == ST_RECV && multi_frame_receive && !cmd_wr |=> st_r == ST_RECV)
		else $error("multi-frame receive ended by itself");
	chk_coll_to_xcv: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
		st_r == ST_COLL && coll_done && field_sync_r[1] && !cmd_wr |=> cmd_r == CMD_TRANSCEIVE)
		else $error("anticollision did not switch to transceive");
	chk_field_loss_stay: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
		st_r == ST_COLL && !field_sync_r[1] && !cmd_wr |=> st_r == ST_COLL ##0 cmd_r == CMD_AUTO_ANTICOLLISION_CMD)
		else $error("field loss ended anticollision");
	chk_tx_empty_idle: assert property (@(posedge ref_clk) disable iff (!rst_n) // R25
		st_r == ST_SEND && !out_v && cmd_r == CMD_TRANSMIT && !cmd_wr |=> idle_event ##1 !idle_event)
		else $error("transmit end did not raise idle event");
	chk_testbus_route: assert property (@(posedge ref_clk) disable iff (!rst_n) // R21
		test_bus_select == TBUS_RECEIVER |=> test_bus == $past(rx_test_signals))
		else $error("test bus routing wrong");
endmodule : ccs_sequencer

// ===== ccs_host_model.sv
// Host controller model driving command writes and FIFO accesses
`timescale 1ns/1ps
module ccs_host_model (
	input wire logic ref_clk, // 40 MHz clock
	output logic cmd_wr, // Command write pulse
	output logic [7:0] cmd_wdata, // Command value
	output logic [7:0] host_fifo_wdata, // FIFO write data
	output logic host_fifo_wr, // FIFO write pulse
	output logic host_fifo_rd, // FIFO pop pulse
	output logic transmit_kick // Start-send pulse
);
	// Quiet strobes from time zero
	initial begin
		cmd_wr = 1'b0;
		cmd_wdata = 8'h00;
		host_fifo_wdata = 8'h00;
		host_fifo_wr = 1'b0;
		host_fifo_rd = 1'b0;
		transmit_kick = 1'b0;
	end
	// command write
	// Command write; released data shows its inverse so nothing stale passes
	task automatic cmd(input logic [7:0] v);
		@(posedge ref_clk);
		#2;
		cmd_wr = 1'b1;
		cmd_wdata = v;
		@(posedge ref_clk);
		#2;
		cmd_wr = 1'b0;
		cmd_wdata = ~v;
	endtask : cmd
	// argument preload
	// One FIFO byte; arguments go in before their command starts
	task automatic put(input logic [7:0] v);
		@(posedge ref_clk);
		#2;
		host_fifo_wr = 1'b1;
		host_fifo_wdata = v;
		@(posedge ref_clk);
		#2;
		host_fifo_wr = 1'b0;
		host_fifo_wdata = ~v;
	endtask : put
	// Pop of the FIFO head
	task automatic pop();
		@(posedge ref_clk);
		#2;
		host_fifo_rd = 1'b1;
		@(posedge ref_clk);
		#2;
		host_fifo_rd = 1'b0;
	endtask : pop
	// send kick
	// Every send phase of transceive starts from this pulse
	task automatic kick();
		@(posedge ref_clk);
		#2;
		transmit_kick = 1'b1;
		@(posedge ref_clk);
		#2;
		transmit_kick = 1'b0;
	endtask : kick
endmodule : ccs_host_model

// ===== contactless_command_sequencer_bench.sv
// Self-checking bench for the contactless command sequencer
`timescale 1ns/1ps
module contactless_command_sequencer_bench
	import ccs_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic ref_clk, reset_n, initiator_role, multi_frame_receive, mode_detector_disable;
	logic rf_field_present, coll_active_mode, coll_is_106k;
	logic cmd_wr, host_fifo_wr, host_fifo_rd, transmit_kick;
	logic [7:0] cmd_wdata, host_fifo_wdata, rx_byte, detected_mode, b, b2;
	logic [6:0] rx_test_signals, test_bus, p;
	logic [4:0] test_bus_select;
	logic tx_byte_ready, rx_byte_valid, rx_frame_end, mode_detected, coll_done, auth_ok, auth_fail;
	logic [7:0] command_register, fifo_rdata, tx_byte, receive_mode_register;
	logic [7:0] serial_rate_register, self_test_register;
	logic fifo_not_empty, fifo_host_ready, tx_active, receiver_on, mode_det_on, crc_force_on;
	logic target_activated_flag, cipher_active_flag, fifo_write_error, protocol_error_flag;
	logic idle_event, receive_done_event, transmit_done_event;
	logic [2:0] ev;
	logic [7:0] tq[$];
	logic [7:0] rq[$];
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	int seed = 80258;
	// Pulse inputs share one vector so a single task drives them all
	assign {tx_byte_ready, rx_byte_valid, rx_frame_end, mode_detected, coll_done, auth_ok,
		auth_fail} = p;
	assign ev = {transmit_done_event, receive_done_event, idle_event};
	ccs_host_model hm (.ref_clk, .cmd_wr, .cmd_wdata, .host_fifo_wdata, .host_fifo_wr,
		.host_fifo_rd, .transmit_kick);
	ccs_sequencer uut (.ref_clk, .reset_n, .cmd_wr, .cmd_wdata, .initiator_role,
		.multi_frame_receive, .mode_detector_disable, .transmit_kick, .host_fifo_wdata,
		.host_fifo_wr, .host_fifo_rd, .rx_byte, .rx_byte_valid, .rx_frame_end, .tx_byte_ready,
		.rf_field_present, .mode_detected, .detected_mode, .coll_done, .coll_active_mode,
		.coll_is_106k, .auth_ok, .auth_fail, .rx_test_signals, .test_bus_select,
		.command_register, .fifo_rdata, .fifo_not_empty, .fifo_host_ready, .tx_byte, .tx_active,
		.receiver_on, .mode_det_on, .receive_mode_register, .crc_force_on, .target_activated_flag,
		.cipher_active_flag, .fifo_write_error, .protocol_error_flag, .idle_event,
		.receive_done_event, .transmit_done_event, .serial_rate_register, .self_test_register,
		.test_bus);
	// Clock and hang guard
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			stop_test();
		end
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic cy(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask : cy
	task automatic pl(input int k);
		cy(1);
		p[k] = 1'b1;
		cy(1);
		p[k] = 1'b0;
	endtask : pl
	// Event pulses last one cycle, so look before waiting
	task automatic wt(input int k);
		bit s = 0;
		for (int j = 0; j < 20 && !s; j++) begin
			if (ev[k] === 1'b1) s = 1;
			else cy(1);
		end
		tests_run++;
		if (!s) begin
			fails++;
			$display("MISMATCH t=%0t event %0d missing", $time, k);
		end
	endtask : wt
	task automatic fill(input int n, input bit to_tx);
		repeat (n) begin
			b = 8'($random(seed));
			if (to_tx) tq.push_back(b);
			else rq.push_back(b);
			hm.put(b);
		end
	endtask : fill
	// Coder takes bytes at an uneven pace, fast or slow
	task automatic pops(input int n);
		repeat (n) begin
			cy(1 + ($unsigned($random(seed)) % 3));
			pl(6);
		end
	endtask : pops
	task automatic dr(input int n);
		repeat (n) begin
			chk(fifo_rdata, rq.pop_front());
			hm.pop();
			cy(2);
		end
	endtask : dr
	task automatic rxb(input int n);
		repeat (n) begin
			b = 8'($random(seed));
			rq.push_back(b);
			rx_byte = b;
			pl(5);
		end
	endtask : rxb
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	// Each byte the coder takes is matched to the oldest noted byte
	always @(posedge ref_clk) begin
		if (tx_byte_ready === 1'b1 && tx_active === 1'b1) begin
			#1;
			b2 = (tq.size() != 0) ? tq.pop_front() : ~tx_byte;
			chk(tx_byte, b2);
		end
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		{reset_n, initiator_role, multi_frame_receive, mode_detector_disable} = 4'h0;
		{rf_field_present, coll_active_mode, coll_is_106k} = 3'h0;
		{rx_byte, detected_mode, rx_test_signals, test_bus_select, p} = '0;
		cy(2);
		reset_n = 1'b1;
		cy(3);
		chk(serial_rate_register, 8'heb);
		chk(self_test_register, 8'h40);
		chk(command_register, 8'h00);
		rx_test_signals = 7'($random(seed));
		test_bus_select = TBUS_RECEIVER;
		cy(2);
		chk(test_bus, rx_test_signals);
		test_bus_select = 5'h01;
		cy(2);
		chk(test_bus, 8'h00);
		// Transmit to empty, then an aborted one whose rest is drained
		fill(3, 1);
		hm.cmd(CMD_TRANSMIT);
		chk(tx_active, 8'h01);
		pops(3);
		wt(2);
		chk(command_register, CMD_IDLE);
		fill(1, 1);
		fill(3, 0);
		cy(1);
		chk(fifo_host_ready, 8'h00);
		hm.put(8'h5a);
		hm.cmd(CMD_TRANSMIT);
		pops(1);
		hm.cmd(CMD_IDLE);
		chk(tx_active, 8'h00);
		dr(3);
		chk(fifo_not_empty, 8'h00);
		// Receive with keep-command writes in mid-frame
		hm.cmd(CMD_RECEIVE);
		chk(receiver_on, 8'h01);
		rxb(2);
		hm.cmd(8'h27);
		chk(command_register, {4'h2, CMD_RECEIVE});
		hm.cmd(CMD_KEEP);
		chk(command_register, CMD_RECEIVE);
		pl(4);
		wt(1);
		wt(0);
		chk(command_register, CMD_IDLE);
		cy(1);
		dr(2);
		multi_frame_receive = 1'b1;
		hm.cmd(CMD_RECEIVE);
		pl(4);
		cy(3);
		chk(command_register, CMD_RECEIVE);
		hm.cmd(CMD_IDLE);
		// Transceive as initiator, then as target with multi-frame receive
		multi_frame_receive = 1'b0;
		initiator_role = 1'b1;
		fill(2, 1);
		hm.cmd(CMD_TRANSCEIVE);
		cy(2);
		chk(receiver_on, 8'h00);
		hm.kick();
		cy(2);
		pops(2);
		cy(3);
		chk(receiver_on, 8'h01);
		pl(4);
		wt(1);
		chk(command_register, CMD_TRANSCEIVE);
		hm.cmd(CMD_IDLE);
		initiator_role = 1'b0;
		multi_frame_receive = 1'b1;
		hm.cmd(CMD_TRANSCEIVE);
		cy(2);
		chk(receiver_on, 8'h01);
		pl(4);
		cy(3);
		chk(receiver_on, 8'h01);
		hm.cmd(CMD_IDLE);
		multi_frame_receive = 1'b0;
		// Anticollision: detector, field loss, passive and active endings
		hm.cmd(CMD_AUTO_ANTICOLLISION_CMD);
		cy(2);
		chk(mode_det_on, 8'h01);
		chk(crc_force_on, 8'h01);
		detected_mode = 8'($random(seed));
		pl(3);
		cy(2);
		chk(receive_mode_register, detected_mode);
		pl(2);
		cy(3);
		chk(command_register, CMD_AUTO_ANTICOLLISION_CMD);
		mode_detector_disable = 1'b1;
		cy(2);
		chk(mode_det_on, 8'h00);
		rf_field_present = 1'b1;
		cy(3);
		hm.cmd(CMD_AUTO_ANTICOLLISION_CMD);
		pl(2);
		cy(2);
		chk(command_register, CMD_TRANSCEIVE);
		chk(target_activated_flag, 8'h01);
		coll_active_mode = 1'b1;
		hm.cmd(CMD_AUTO_ANTICOLLISION_CMD);
		pl(2);
		cy(2);
		chk(target_activated_flag, 8'h00);
		hm.cmd(CMD_IDLE);
		// Self-ending and open-ended codes
		tq.delete();
		hm.cmd(CMD_CONFIG);
		wt(0);
		hm.cmd(CMD_RANDOM);
		wt(0);
		// CRC start after config and random ID; no self-test value or FIFO byte is written first
		hm.cmd(CMD_CRC);
		cy(3);
		chk(command_register, CMD_CRC);
		// Authentication: blocked FIFO, failure, success; then soft reset
		hm.put(8'h60);
		fill(3, 0);
		hm.cmd(CMD_AUTHENT);
		hm.put(8'h61);
		cy(1);
		chk(fifo_write_error, 8'h01);
		pl(0);
		cy(1);
		chk(protocol_error_flag, 8'h01);
		chk(cipher_active_flag, 8'h00);
		chk(command_register, CMD_AUTHENT);
		pl(1);
		wt(0);
		chk(cipher_active_flag, 8'h01);
		hm.cmd(CMD_SOFTWARE_RESET_CMD);
		wt(0);
		chk(fifo_write_error, 8'h00);
		chk(protocol_error_flag, 8'h00);
		chk(serial_rate_register, 8'heb);
		stop_test();
	end
endmodule : contactless_command_sequencer_bench
